// ---- core/ccpu_pkg.sv ----
package ccpu_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_TIMER  = 8'h04;
    localparam logic [7:0] OFF_RELOAD = 8'h08;
    localparam logic [7:0] OFF_PRESC  = 8'h0C;
    localparam logic [7:0] OFF_CHCTRL = 8'h10;
    localparam logic [7:0] OFF_CAPCTL = 8'h14;
    localparam logic [7:0] OFF_IEN    = 8'h18;
    localparam logic [7:0] OFF_IFLAG  = 8'h1C;
    localparam logic [7:0] OFF_CMP0   = 8'h20;
    localparam logic [7:0] OFF_CAP0   = 8'h30;
    localparam logic [7:0] OFF_CAP1   = 8'h34;
    localparam logic [7:0] OFF_STATUS = 8'h38;
    // ctrl fields
    localparam int CTRL_MODE = 0;
    localparam int CTRL_DOWN = 2;
    localparam int CTRL_BYTE = 3;
    localparam int CTRL_RUN  = 4;
    localparam int CTRL_DIV  = 8;
    // channel control fields
    localparam int CH_EN   = 0;
    localparam int CH_POL  = 4;
    localparam int CH_PIN  = 8;
    localparam int CH_ALT  = 12;
    // capture control fields
    localparam int CAP_RISE = 0;
    localparam int CAP_FILT = 2;
    localparam int CAP_CNT  = 4;
    localparam int CNT_W    = 4;
    // flag positions: overflow, capture 0/1, compare A..D
    localparam int FL_OVF = 0;
    localparam int FL_CAP = 1;
    localparam int FL_CMP = 3;
    localparam int N_FLAG = 7;
    localparam int FILT_N = 4;
    localparam logic [15:0] TOP16 = 16'hFFFF;
    localparam logic [15:0] TOP8  = 16'h00FF;
    localparam logic [9:0]  PRE_TOP = 10'h3FF;
    typedef enum logic [1:0] {
        CCPU_BASIC = 2'b00,
        CCPU_ASYM  = 2'b01,
        CCPU_SYM   = 2'b10,
        CCPU_RSVD  = 2'b11
    } ccpu_mode_t;
endpackage

// ---- core/ccpu_capture_in.sv ----
`timescale 1ns/1ns
module ccpu_capture_in #(
    parameter int CNT_W = 4
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             pin,
    input  wire logic             rise_sel,
    input  wire logic             filt_en,
    input  wire logic [CNT_W-1:0] evt_cnt,
    output logic                  capture
);
    logic       s1_q, s2_q, lvl_q, lvl_d;
    logic [3:0] hist_q;
    logic [CNT_W-1:0] cnt_q;
    logic       edge_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q   <= 1'b0;
            s2_q   <= 1'b0;
            hist_q <= 4'h0;
        end else begin
            s1_q   <= pin;
            s2_q   <= s1_q;
            hist_q <= {hist_q[2:0], s2_q};
        end
    end

    // filter accepts a level only when four samples agree
    always_comb begin
        lvl_d = lvl_q;
        if (!filt_en)
            lvl_d = hist_q[0];
        else if (hist_q == 4'hF)
            lvl_d = 1'b1;
        else if (hist_q == 4'h0)
            lvl_d = 1'b0;
    end

    assign edge_ok = (lvl_d != lvl_q) && (lvl_d == rise_sel);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_q   <= 1'b0;
            cnt_q   <= '0;
            capture <= 1'b0;
        end else begin
            lvl_q   <= lvl_d;
            capture <= 1'b0;
            if (edge_ok) begin
                if (cnt_q >= evt_cnt) begin
                    cnt_q   <= '0;
                    capture <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end
endmodule // ccpu_capture_in

// ---- core/ccpu_unit.sv ----
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module ccpu_unit (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  cap_pin,
    input  wire logic        pll_clk_in,
    output logic             pll_ref_o,
    output logic [3:0]       pwm_o,
    output logic [3:0]       pwm_oe,
    output logic             irq_o
);
    ////////////////////////////////////////////////////////////////////
    logic [15:0] ctrl_q, chctrl_q, capctl_q;
    logic [15:0] tmr_q, tmr_d, reload_q, top;
    logic [9:0]  presc_q, pre_cnt_q;
    logic [15:0] cmp_q [4];
    logic [15:0] cap_q [2];
    logic [6:0]  ien_q, flag_q, flag_set;
    logic [3:0]  halt_q, pin_q, div_q;
    logic        sym_down_q, cycle_q, pll1_q, pll2_q, pll3_q;
    logic        unit_tick, pre_tick, wrap, apb_wr, apb_rd, map_hit;
    logic [1:0]  cap_evt;
    logic [3:0]  cmp_hit;
    ccpu_pkg::ccpu_mode_t mode;
    logic        count_down;

    assign mode   = ccpu_pkg::ccpu_mode_t'(ctrl_q[ccpu_pkg::CTRL_MODE +: 2]);
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    assign top    = ctrl_q[ccpu_pkg::CTRL_BYTE] ? ccpu_pkg::TOP8
                                               : ccpu_pkg::TOP16;

    ////////////////////////////////////////////////////////////////////
    // pll reference divider and pll clock sampling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q     <= 4'h0;
            pll_ref_o <= 1'b0;
        end else if (div_q >= ctrl_q[ccpu_pkg::CTRL_DIV +: 4]) begin
            div_q     <= 4'h0;
            pll_ref_o <= 1'b1;
        end else begin
            div_q     <= div_q + 4'h1;
            pll_ref_o <= 1'b0;
        end
    end

    // the pll output is foreign to pclk: two flops before any use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll1_q <= 1'b0;
            pll2_q <= 1'b0;
            pll3_q <= 1'b0;
        end else begin
            pll1_q <= pll_clk_in;
            pll2_q <= pll1_q;
            pll3_q <= pll2_q;
        end
    end

    // limitation: pll edges faster than pclk/2 are not seen
    assign unit_tick = ctrl_q[ccpu_pkg::CTRL_RUN] &&
        ((mode == ccpu_pkg::CCPU_BASIC) || (pll2_q && !pll3_q));

    ////////////////////////////////////////////////////////////////////
    // prescaler: counts up from the reload value to all ones
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pre_cnt_q <= 10'h000;
        else if (unit_tick) begin
            if (pre_cnt_q == ccpu_pkg::PRE_TOP)
                pre_cnt_q <= presc_q;
            else
                pre_cnt_q <= pre_cnt_q + 10'h001;
        end
    end

    assign pre_tick = unit_tick && (pre_cnt_q == ccpu_pkg::PRE_TOP);

    ////////////////////////////////////////////////////////////////////
    // timer next value
    always_comb begin
        unique case (mode)
            ccpu_pkg::CCPU_ASYM: count_down = 1'b1;
            ccpu_pkg::CCPU_SYM:  count_down = sym_down_q;
            default: count_down = ctrl_q[ccpu_pkg::CTRL_DOWN];
        endcase
    end

    always_comb begin
        wrap  = 1'b0;
        tmr_d = tmr_q;
        if (mode == ccpu_pkg::CCPU_SYM) begin
            if (!sym_down_q)
                tmr_d = (tmr_q >= reload_q) ? tmr_q - 16'h0001
                                           : tmr_q + 16'h0001;
            else if (tmr_q == 16'h0000) begin
                tmr_d = 16'h0001;
                wrap  = 1'b1;
            end else
                tmr_d = tmr_q - 16'h0001;
        end else if (count_down) begin
            if (tmr_q == 16'h0000) begin
                tmr_d = reload_q & top;
                wrap  = 1'b1;
            end else
                tmr_d = tmr_q - 16'h0001;
        end else begin
            if (tmr_q >= top) begin
                tmr_d = reload_q & top;
                wrap  = 1'b1;
            end else
                tmr_d = tmr_q + 16'h0001;
        end
    end

    // a bus write to the timer wins over counting in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            tmr_q <= 16'h0000;
        else if (apb_wr && paddr == ccpu_pkg::OFF_TIMER)
            tmr_q <= pwdata[15:0] & top;
        else if (pre_tick)
            tmr_q <= tmr_d;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sym_down_q <= 1'b0;
            cycle_q    <= 1'b0;
        end else if (pre_tick) begin
            if (mode == ccpu_pkg::CCPU_SYM) begin
                if (!sym_down_q && tmr_q >= reload_q)
                    sym_down_q <= 1'b1;
                else if (sym_down_q && tmr_q == 16'h0000)
                    sym_down_q <= 1'b0;
            end
            if (wrap)
                cycle_q <= ~cycle_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // compare channels
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ch
            logic en, alt, gate;
            assign en = chctrl_q[ccpu_pkg::CH_EN + gi];
            assign alt = chctrl_q[ccpu_pkg::CH_ALT + gi/2] &&
                         (mode == ccpu_pkg::CCPU_ASYM);
            assign gate = !alt || (cycle_q == 1'(gi % 2));
            assign cmp_hit[gi] = en && pre_tick &&
                (tmr_d == (cmp_q[gi] & top));

            // halt value changes only on compare or reload events
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    halt_q[gi] <= 1'b0;
                else if (cmp_hit[gi]) begin
                    unique case (mode)
                        ccpu_pkg::CCPU_BASIC: halt_q[gi] <= ~halt_q[gi];
                        ccpu_pkg::CCPU_ASYM:  halt_q[gi] <= 1'b0;
                        ccpu_pkg::CCPU_SYM:   halt_q[gi] <= sym_down_q;
                        default:              halt_q[gi] <= halt_q[gi];
                    endcase
                end else if (en && pre_tick && wrap &&
                             mode == ccpu_pkg::CCPU_ASYM)
                    halt_q[gi] <= 1'b1;
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pwm_o[gi]  <= 1'b0;
                    pwm_oe[gi] <= 1'b0;
                end else begin
                    pwm_o[gi]  <= gate && (halt_q[gi] ^
                        chctrl_q[ccpu_pkg::CH_POL + gi]);
                    pwm_oe[gi] <= en &&
                        chctrl_q[ccpu_pkg::CH_PIN + gi];
                end
            end
        end
    endgenerate

    assign pin_q = halt_q;

    ////////////////////////////////////////////////////////////////////
    // capture inputs
    generate
        for (gi = 0; gi < 2; gi++) begin : g_cap
            ccpu_capture_in #(.CNT_W(ccpu_pkg::CNT_W)) u_cap (
                .pclk     (pclk),
                .presetn  (presetn),
                .pin      (cap_pin[gi]),
                .rise_sel (capctl_q[ccpu_pkg::CAP_RISE + gi]),
                .filt_en  (capctl_q[ccpu_pkg::CAP_FILT + gi]),
                .evt_cnt  (capctl_q[ccpu_pkg::CAP_CNT +
                                    gi*ccpu_pkg::CNT_W +: ccpu_pkg::CNT_W]),
                .capture  (cap_evt[gi])
            );

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    cap_q[gi] <= 16'h0000;
                else if (cap_evt[gi])
                    cap_q[gi] <= tmr_q;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // flags: write one to clear, a new event in the same cycle wins
    assign flag_set = {cmp_hit, cap_evt, pre_tick && wrap};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            flag_q <= 7'h00;
        else if (apb_wr && paddr == ccpu_pkg::OFF_IFLAG)
            flag_q <= (flag_q & ~pwdata[6:0]) | flag_set;
        else
            flag_q <= flag_q | flag_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_o <= 1'b0;
        else
            irq_o <= |(flag_q & ien_q);
    end

    ////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q   <= 16'h0000;
            reload_q <= 16'h0000;
            presc_q  <= 10'h000;
            chctrl_q <= 16'h0000;
            capctl_q <= 16'h0000;
            ien_q    <= 7'h00;
            for (int i = 0; i < 4; i++)
                cmp_q[i] <= 16'h0000;
        end else if (apb_wr) begin
            unique case (paddr)
                ccpu_pkg::OFF_CTRL:   ctrl_q   <= pwdata[15:0];
                ccpu_pkg::OFF_RELOAD: reload_q <= pwdata[15:0];
                ccpu_pkg::OFF_PRESC:  presc_q  <= pwdata[9:0];
                ccpu_pkg::OFF_CHCTRL: chctrl_q <= pwdata[15:0];
                ccpu_pkg::OFF_CAPCTL: capctl_q <= pwdata[15:0];
                ccpu_pkg::OFF_IEN:    ien_q    <= pwdata[6:0];
                default: begin
                    for (int i = 0; i < 4; i++)
                        if (paddr == ccpu_pkg::OFF_CMP0 + 8'(4 * i))
                            cmp_q[i] <= pwdata[15:0];
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // apb read: data latched in setup so 16-bit values read whole
    always_comb begin
        map_hit = 1'b1;
        unique case (paddr)
            ccpu_pkg::OFF_CTRL, ccpu_pkg::OFF_TIMER, ccpu_pkg::OFF_RELOAD,
            ccpu_pkg::OFF_PRESC, ccpu_pkg::OFF_CHCTRL, ccpu_pkg::OFF_CAPCTL,
            ccpu_pkg::OFF_IEN, ccpu_pkg::OFF_IFLAG, ccpu_pkg::OFF_CAP0,
            ccpu_pkg::OFF_CAP1, ccpu_pkg::OFF_STATUS: map_hit = 1'b1;
            default: map_hit = (paddr >= ccpu_pkg::OFF_CMP0) &&
                               (paddr <= ccpu_pkg::OFF_CMP0 + 8'h0C) &&
                               (paddr[1:0] == 2'b00);
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (apb_rd) begin
            unique case (paddr)
                ccpu_pkg::OFF_CTRL:   prdata <= {16'h0000, ctrl_q};
                ccpu_pkg::OFF_TIMER:  prdata <= {16'h0000, tmr_q};
                ccpu_pkg::OFF_RELOAD: prdata <= {16'h0000, reload_q};
                ccpu_pkg::OFF_PRESC:  prdata <= {22'h000000, presc_q};
                ccpu_pkg::OFF_CHCTRL: prdata <= {16'h0000, chctrl_q};
                ccpu_pkg::OFF_CAPCTL: prdata <= {16'h0000, capctl_q};
                ccpu_pkg::OFF_IEN:    prdata <= {25'h0000000, ien_q};
                ccpu_pkg::OFF_IFLAG:  prdata <= {25'h0000000, flag_q};
                ccpu_pkg::OFF_CAP0:   prdata <= {16'h0000, cap_q[0]};
                ccpu_pkg::OFF_CAP1:   prdata <= {16'h0000, cap_q[1]};
                ccpu_pkg::OFF_STATUS:
                    prdata <= {26'h0000000, cycle_q, count_down, pin_q};
                default: begin
                    prdata <= 32'h0000_0000;
                    for (int i = 0; i < 4; i++)
                        if (paddr == ccpu_pkg::OFF_CMP0 + 8'(4 * i))
                            prdata <= {16'h0000, cmp_q[i]};
                end
            endcase
        end
    end

    // zero wait states: ready and error follow the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !map_hit;
        end
    end
endmodule // ccpu_unit

// ---- dv/ccpu_far_model.sv ----
`timescale 1ns/1ns
module ccpu_far_model (
    input  wire logic       pclk,
    output logic            pll_clk_in,
    output logic [1:0]      cap_pin,
    input  wire logic [3:0] pwm_o,
    input  wire logic [3:0] pwm_oe
);
    logic [3:0] load_q;
    ////////////////////////////////////////////////////////////////////////
    // the loop output runs free and unrelated in phase to pclk
    initial begin
        pll_clk_in = 1'b0;
        cap_pin    = 2'b00;
        forever #11 pll_clk_in = ~pll_clk_in;
    end
    // a load sees nothing while its pin is left undriven
    always_comb load_q = pwm_o & pwm_oe;
    ////////////////////////////////////////////////////////////////////////
    task automatic set_pin(input int ch, input logic lvl, input int n);
        @(posedge pclk);
        cap_pin[ch] <= lvl;
        repeat (n) @(posedge pclk);
    endtask
endmodule // ccpu_far_model

// ---- dv/ccpu_unit_props.sv ----
`timescale 1ns/1ns
module ccpu_unit_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [1:0]  cap_pin,
    input wire logic        pll_clk_in,
    input wire logic        pll_ref_o,
    input wire logic [3:0]  pwm_o,
    input wire logic [3:0]  pwm_oe,
    input wire logic        irq_o
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       wr_ok;
    logic [3:0] oe_exp;
    logic [3:0] div_q;
    logic [4:0] gap_q;
    logic [5:0] quiet_q;
    assign wr_ok  = pready && pwrite && !pslverr;
    assign oe_exp = pwdata[3:0] & pwdata[11:8];
    ////////////////////////////////////////////////////////////////////////
    // spacing is judged only long after the divider was last rewritten,
    // since the phase right after a change is left to the design
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q   <= 4'h0;
            quiet_q <= 6'h00;
        end else if (wr_ok && paddr == ccpu_pkg::OFF_CTRL) begin
            div_q   <= pwdata[11:8];
            quiet_q <= 6'h00;
        end else if (quiet_q != 6'h3F) begin
            quiet_q <= quiet_q + 6'h01;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= 5'h00;
        end else if (pll_ref_o) begin
            gap_q <= 5'h00;
        end else if (gap_q != 5'h1F) begin
            gap_q <= gap_q + 5'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    chk_answer_next:
        assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    chk_ready_pulse:
        assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_err_ready:
        assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_err_zero:
        assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    chk_hole_refused:
        assert property (pready && paddr == 8'hFC |-> pslverr)
        else $error("unmapped address accepted");
    chk_irq_masked:
        assert property (wr_ok && paddr == ccpu_pkg::OFF_IEN
            && pwdata[6:0] == 7'h00 |-> ##2 !irq_o)
        else $error("request with all enables off");
    chk_oe_follow:
        assert property (wr_ok && paddr == ccpu_pkg::OFF_CHCTRL
            |-> ##2 pwm_oe == $past(oe_exp, 2))
        else $error("output enable not enable and pin mode");
    chk_ref_gap:
        assert property (pll_ref_o && quiet_q >= 6'd50
            |-> gap_q == {1'b0, div_q})
        else $error("reference pulse spacing wrong");
endmodule // ccpu_unit_props
bind ccpu_unit ccpu_unit_props u_ccpu_unit_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cap_pin(cap_pin),
    .pll_clk_in(pll_clk_in), .pll_ref_o(pll_ref_o), .pwm_o(pwm_o),
    .pwm_oe(pwm_oe), .irq_o(irq_o));

// ---- dv/tb_ccpu_unit.sv ----
`timescale 1ns/1ns
module tb_ccpu_unit;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        pll_clk_in, pll_ref_o, irq_o, err, dn, p;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, c0, t0;
    logic [1:0]  cap_pin;
    logic [3:0]  pwm_o, pwm_oe;
    int          miscompares, n_tests;
    ccpu_unit u_ccpu_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cap_pin(cap_pin), .pll_clk_in(pll_clk_in), .pll_ref_o(pll_ref_o),
        .pwm_o(pwm_o), .pwm_oe(pwm_oe), .irq_o(irq_o));
    ccpu_far_model u_ccpu_far_model (.pclk(pclk), .pll_clk_in(pll_clk_in),
        .cap_pin(cap_pin), .pwm_o(pwm_o), .pwm_oe(pwm_oe));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rng(input logic [31:0] g, input logic [31:0] lo, hi);
        chk({31'h0, g >= lo && g <= hi}, 32'h1);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // one idle cycle after each transfer keeps every signal to one
    // assignment per time step
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 16) begin
            miscompares++;
            final_report();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdt(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rdt(ccpu_pkg::OFF_CTRL);
        chk(rd, 32'h0);
        rdt(8'hFC);
        chk({31'h0, err}, 32'h1);
        wr(ccpu_pkg::OFF_RELOAD, 32'h0000_1234);
        rdt(ccpu_pkg::OFF_RELOAD);
        chk(rd, 32'h0000_1234);
        $display("done regs");
    endtask
    task automatic t_ovf();
        wr(ccpu_pkg::OFF_PRESC, 32'h0000_03FF);
        wr(ccpu_pkg::OFF_RELOAD, 32'h0000_1200);
        wr(ccpu_pkg::OFF_TIMER, 32'h0000_FFF0);
        wr(ccpu_pkg::OFF_IEN, 32'h0000_0001);
        wr(ccpu_pkg::OFF_CTRL, 32'h0000_0010);
        // the prescaler counts up from zero once before its first reload
        cyc(1054);
        rdt(ccpu_pkg::OFF_TIMER);
        rng(rd, 32'h1200, 32'h1240);
        rdt(ccpu_pkg::OFF_IFLAG);
        chk(rd & 32'h1, 32'h1);
        chk({31'h0, irq_o}, 32'h1);
        wr(ccpu_pkg::OFF_IEN, 32'h0);
        cyc(3);
        chk({31'h0, irq_o}, 32'h0);
        wr(ccpu_pkg::OFF_CTRL, 32'h0);
        wr(ccpu_pkg::OFF_RELOAD, 32'h0000_0010);
        wr(ccpu_pkg::OFF_TIMER, 32'h0000_00F0);
        wr(ccpu_pkg::OFF_IFLAG, 32'h0000_007F);
        wr(ccpu_pkg::OFF_CTRL, 32'h0000_0018);
        cyc(40);
        rdt(ccpu_pkg::OFF_TIMER);
        rng(rd, 32'h10, 32'h60);
        rdt(ccpu_pkg::OFF_IFLAG);
        chk(rd & 32'h1, 32'h1);
        $display("done overflow");
    endtask
    task automatic t_dir();
        wr(ccpu_pkg::OFF_CTRL, 32'h0);
        wr(ccpu_pkg::OFF_TIMER, 32'h0000_0800);
        wr(ccpu_pkg::OFF_CTRL, 32'h0000_0014);
        cyc(10);
        rdt(ccpu_pkg::OFF_TIMER);
        t0 = rd;
        rng(t0, 32'h07D0, 32'h07FF);
        wr(ccpu_pkg::OFF_CTRL, 32'h0000_0010);
        cyc(10);
        rdt(ccpu_pkg::OFF_TIMER);
        rng(rd, t0 + 32'h1, t0 + 32'h30);
        wr(ccpu_pkg::OFF_CTRL, 32'h0000_0011);
        rdt(ccpu_pkg::OFF_TIMER);
        t0 = rd;
        cyc(40);
        rdt(ccpu_pkg::OFF_TIMER);
        rng(rd, t0 - 32'h30, t0 - 32'h1);
        wr(ccpu_pkg::OFF_CTRL, 32'h0);
        wr(ccpu_pkg::OFF_TIMER, 32'h0);
        wr(ccpu_pkg::OFF_CTRL, 32'h0000_0012);
        dn = 1'b0;
        t0 = 32'h0;
        repeat (8) begin
            cyc(8);
            rdt(ccpu_pkg::OFF_TIMER);
            rng(rd, 32'h0, 32'h10);
            if (rd < t0) begin
                dn = 1'b1;
            end
            t0 = rd;
        end
        chk({31'h0, dn}, 32'h1);
        $display("done direction");
    endtask
    task automatic t_presc();
        wr(ccpu_pkg::OFF_CTRL, 32'h0);
        wr(ccpu_pkg::OFF_PRESC, 32'h0000_03FC);
        wr(ccpu_pkg::OFF_TIMER, 32'h0);
        wr(ccpu_pkg::OFF_CTRL, 32'h0000_0010);
        rdt(ccpu_pkg::OFF_TIMER);
        t0 = rd;
        cyc(80);
        rdt(ccpu_pkg::OFF_TIMER);
        rng(rd - t0, 32'd19, 32'd22);
        wr(ccpu_pkg::OFF_PRESC, 32'h0000_03FF);
        $display("done prescaler");
    endtask
    task automatic t_cap();
        wr(ccpu_pkg::OFF_CAPCTL, 32'h0000_0001);
        wr(ccpu_pkg::OFF_IFLAG, 32'h0000_007F);
        u_ccpu_far_model.set_pin(0, 1'b1, 12);
        rdt(ccpu_pkg::OFF_CAP0);
        c0 = rd;
        rdt(ccpu_pkg::OFF_TIMER);
        rng(rd - c0, 32'd5, 32'd40);
        rdt(ccpu_pkg::OFF_IFLAG);
        chk(rd & 32'h6, 32'h2);
        u_ccpu_far_model.set_pin(1, 1'b1, 12);
        rdt(ccpu_pkg::OFF_CAP1);
        chk(rd, 32'h0);
        u_ccpu_far_model.set_pin(1, 1'b0, 12);
        rdt(ccpu_pkg::OFF_IFLAG);
        chk(rd & 32'h4, 32'h4);
        wr(ccpu_pkg::OFF_CAPCTL, 32'h0000_0005);
        u_ccpu_far_model.set_pin(0, 1'b0, 2);
        u_ccpu_far_model.set_pin(0, 1'b1, 12);
        rdt(ccpu_pkg::OFF_CAP0);
        chk(rd, c0);
        wr(ccpu_pkg::OFF_CAPCTL, 32'h0000_0021);
        for (int i = 0; i < 3; i++) begin
            u_ccpu_far_model.set_pin(0, 1'b0, 12);
            u_ccpu_far_model.set_pin(0, 1'b1, 12);
            rdt(ccpu_pkg::OFF_CAP0);
            chk({31'h0, rd != c0}, {31'h0, i == 2});
        end
        $display("done capture");
    endtask
    task automatic t_cmp();
        wr(ccpu_pkg::OFF_CTRL, 32'h0);
        wr(ccpu_pkg::OFF_TIMER, 32'h0);
        wr(ccpu_pkg::OFF_CMP0, 32'h0000_0040);
        wr(ccpu_pkg::OFF_IFLAG, 32'h0000_007F);
        wr(ccpu_pkg::OFF_CHCTRL, 32'h0000_0101);
        cyc(2);
        chk({28'h0, pwm_oe}, 32'h1);
        wr(ccpu_pkg::OFF_CTRL, 32'h0000_0010);
        cyc(90);
        wr(ccpu_pkg::OFF_CTRL, 32'h0);
        rdt(ccpu_pkg::OFF_IFLAG);
        chk(rd & 32'h78, 32'h08);
        p = pwm_o[0];
        chk({28'h0, u_ccpu_far_model.load_q}, 32'h1);
        rdt(ccpu_pkg::OFF_STATUS);
        chk(rd & 32'hF, 32'h1);
        wr(ccpu_pkg::OFF_CHCTRL, 32'h0000_0111);
        cyc(3);
        chk({31'h0, pwm_o[0]}, {31'h0, ~p});
        $display("done compare");
    endtask
    task automatic t_ref();
        int nv[4] = '{0, 3, 5, 15};
        foreach (nv[j]) begin
            wr(ccpu_pkg::OFF_CTRL, nv[j] << 8);
            cyc(40);
            t0 = 32'h0;
            repeat (48) begin
                @(posedge pclk);
                t0 = t0 + pll_ref_o;
            end
            chk(t0, 48 / (nv[j] + 1));
        end
        $display("done reference");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        miscompares = 0;
        n_tests     = 0;
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 8'h00;
        pwdata      = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_ovf();
        t_dir();
        t_presc();
        t_cap();
        t_cmp();
        t_ref();
        final_report();
    end
endmodule // tb_ccpu_unit
